//--- logic/sgan_autoneg_regs.sv
/*
 * Auto-negotiation management registers 4 to 8: advertisement,
 * partner ability, expansion, next-page transmit and receive, behind a
 * serial management slave.
 * Assumes the auto-negotiation state machine consumes advertWord and
 * npTxWord and supplies partner words and page events as one-cycle
 * pulses synchronous to core_clk.
 */
// How it works
// - MAC mode advertisement reads fixed 0x0001
// - PHY mode configuration port also loads advertisement fields
// - PHY mode bit 15 writable link, default 0
// - PHY mode bit 14 writable acknowledge, default 0
// - PHY mode duplex and speed writable, default 0
// - Advertisement bits 13, 9:1 zero; bit 0 one
// - Partner register reports received word, link default 1
// - Partner bits 13, 9:1 zero; bit 0 one
// - Page received flag sets, clears on read
// - Expansion bit 2 one, bit 1 page received, others zero
// - Next-page bit 15 writable; bit 14 zero
// - Message page and comply bits writable
// - Toggle bit alternates per sent page, from zero
// - Code field writable, defaults to null message
// - Next-page transmit reads zero without support
// - Next-page receive holds partner page, default zero
// - Hard reset, lock loss, soft reset restore defaults
module sgan_autoneg_regs
    import sgan_pkg::*;
#(
    parameter bit PHY_MODE = 1'b0,
    parameter bit NEXT_PAGE_EN = 1'b0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic [4:0] phyAddr,
    input wire logic clockManagerLocked,
    input wire logic softReset,
    input wire logic anCfgValid,
    input wire sgan_link_word_t anCfgWord,
    output logic [15:0] advertWord,
    input wire logic partnerValid,
    input wire sgan_link_word_t partnerWord,
    input wire logic pageReceived,
    output sgan_np_word_t npTxWord,
    input wire logic npTxSent,
    input wire logic npRxValid,
    input wire sgan_np_word_t npRxWord
);

    sgan_mgmt_req_t req;
    logic regClear;
    logic [15:0] rdData_r;
    logic [15:0] rdData_nxt;
    sgan_link_word_t advert_r;
    sgan_link_word_t partner_r;
    logic pageRx_r;
    sgan_np_word_t npTx_r;
    sgan_np_word_t npRx_r;
    logic [15:0] advertImage;
    logic [15:0] expImage;

    // Combined synchronous clear
    sgan_reset_ctrl u_reset (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clockManagerLocked(clockManagerLocked),
        .softReset(softReset),
        .regClear(regClear)
    );

    // Management frame engine
    sgan_mdio_slave u_mdio (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .mdc(mdc),
        .mdioIn(mdioIn),
        .phyAddr(phyAddr),
        .rdData(rdData_r),
        .req(req),
        .mdioOut(mdioOut),
        .mdioOe(mdioOe)
    );

    // Advertisement storage, used only in PHY mode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            advert_r <= LINK_WORD_ZERO;
        end else if (regClear) begin
            advert_r <= LINK_WORD_ZERO;
        end else if (PHY_MODE) begin
            if (req.wr && req.addr == REG_ADVERT) begin
                advert_r <= sgan_unpack_link(req.data);
            end else if (anCfgValid) begin
                advert_r <= anCfgWord;
            end
        end
    end

    // Register image, fixed in MAC mode
    assign advertImage = PHY_MODE ? sgan_pack_link(advert_r) : ADVERT_MAC_VALUE;
    assign advertWord = advertImage;

    // Partner ability captured from the received base page
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            partner_r <= PARTNER_RESET;
        end else if (regClear) begin
            partner_r <= PARTNER_RESET;
        end else if (partnerValid) begin
            partner_r <= partnerWord;
        end
    end

    // Page received flag, a new page wins over the clearing read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pageRx_r <= 1'b0;
        end else if (regClear) begin
            pageRx_r <= 1'b0;
        end else if (pageReceived) begin
            pageRx_r <= 1'b1;
        end else if (req.rd && req.addr == REG_EXPANSION) begin
            pageRx_r <= 1'b0;
        end
    end

    // Expansion image
    always_comb begin
        expImage = ZERO_WORD;
        expImage[EXP_NP_ABLE_BIT] = 1'b1;
        expImage[EXP_PAGE_RX_BIT] = pageRx_r;
    end

    // Next-page transmit word and its toggle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            npTx_r <= NP_TX_RESET;
        end else if (regClear) begin
            npTx_r <= NP_TX_RESET;
        end else begin
            if (req.wr && req.addr == REG_NP_TX) begin
                npTx_r.nextPage <= req.data[15];
                npTx_r.msgPage <= req.data[13];
                npTx_r.comply <= req.data[12];
                npTx_r.code <= req.data[10:0];
            end
            if (npTxSent) begin
                npTx_r.toggle <= !npTx_r.toggle;
            end
        end
    end

    assign npTxWord = npTx_r;

    // Next-page receive word from the partner
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            npRx_r <= NP_RX_RESET;
        end else if (regClear) begin
            npRx_r <= NP_RX_RESET;
        end else if (npRxValid) begin
            npRx_r <= npRxWord;
        end
    end

    // Read multiplexer, unmapped addresses return zero
    always_comb begin
        case (req.addr)
            REG_ADVERT: rdData_nxt = advertImage;
            REG_PARTNER: rdData_nxt = sgan_pack_link(partner_r);
            REG_EXPANSION: rdData_nxt = expImage;
            REG_NP_TX: rdData_nxt = NEXT_PAGE_EN ? npTx_r : ZERO_WORD;
            REG_NP_RX: rdData_nxt = npRx_r;
            default: rdData_nxt = ZERO_WORD;
        endcase
    end

    // Read data captured on the read request
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_r <= ZERO_WORD;
        end else if (req.rd) begin
            rdData_r <= rdData_nxt;
        end
    end

endmodule

//--- logic/sgan_mdio_slave.sv
/*
 * Serial management slave: decodes clause-22 style frames on mdc and
 * mdio, issues one-cycle read and write requests, and shifts read data
 * out after the turnaround.
 * Assumes mdc and mdioIn are synchronous to core_clk and that mdc is
 * much slower than core_clk; preamble may be suppressed.
 */
module sgan_mdio_slave
    import sgan_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic mdc,
    input wire logic mdioIn,
    input wire logic [4:0] phyAddr,
    input wire logic [15:0] rdData,
    output sgan_mgmt_req_t req,
    output logic mdioOut,
    output logic mdioOe
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_WR = 3'b010,
        ST_RD = 3'b011
    } sgan_mdio_state_t;

    sgan_mdio_state_t state_r;
    logic mdcPrev_r;
    logic [15:0] sr_r;
    logic [16:0] outSr_r;
    logic [4:0] cnt_r;
    logic [4:0] regAddr_r;
    logic mine_r;
    sgan_mgmt_req_t req_r;
    logic mdioOut_r;
    logic mdioOe_r;
    logic mdcRise;
    logic mdcFall;
    logic [11:0] hdr;

    // Edge detection on the management clock
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mdcPrev_r <= 1'b0;
        end else begin
            mdcPrev_r <= mdc;
        end
    end

    assign mdcRise = mdc && !mdcPrev_r;
    assign mdcFall = !mdc && mdcPrev_r;
    assign hdr = {sr_r[10:0], mdioIn};

    // Frame sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            sr_r <= 16'hFFFF;
            outSr_r <= 17'h00000;
            cnt_r <= 5'h00;
            regAddr_r <= 5'h00;
            mine_r <= 1'b0;
            req_r <= '0;
            mdioOut_r <= 1'b0;
            mdioOe_r <= 1'b0;
        end else begin
            req_r.rd <= 1'b0;
            req_r.wr <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (mdcRise) begin
                        sr_r <= {sr_r[14:0], mdioIn};
                        cnt_r <= 5'h00;
                        if (!sr_r[0] && mdioIn) begin  // Start code 01
                            state_r <= ST_HDR;
                        end
                    end
                end
                ST_HDR: begin
                    if (mdcRise) begin
                        sr_r <= {sr_r[14:0], mdioIn};
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == MDIO_HDR_LAST) begin
                            cnt_r <= 5'h00;
                            regAddr_r <= hdr[4:0];
                            mine_r <= (hdr[9:5] == phyAddr) && (hdr[11:10] == MDIO_OP_WRITE);
                            if ((hdr[9:5] == phyAddr) && (hdr[11:10] == MDIO_OP_READ)) begin
                                req_r.rd <= 1'b1;
                                req_r.addr <= hdr[4:0];
                                state_r <= ST_RD;
                            end else begin
                                state_r <= ST_WR;  // Own write, or skip a foreign frame
                            end
                        end
                    end
                end
                ST_WR: begin
                    if (mdcRise) begin
                        sr_r <= {sr_r[14:0], mdioIn};
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == MDIO_WR_LAST) begin
                            req_r.wr <= mine_r;
                            req_r.addr <= regAddr_r;
                            req_r.data <= {sr_r[14:0], mdioIn};
                            sr_r <= 16'hFFFF;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_RD: begin
                    if (mdcFall) begin
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == 5'h00) begin
                            outSr_r <= {1'b0, rdData};  // Turnaround zero, then data
                        end else if (cnt_r == MDIO_RD_RELEASE) begin
                            mdioOe_r <= 1'b0;
                            sr_r <= 16'hFFFF;
                            state_r <= ST_IDLE;
                        end else begin
                            mdioOut_r <= outSr_r[16];
                            mdioOe_r <= 1'b1;
                            outSr_r <= {outSr_r[15:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign req = req_r;
    assign mdioOut = mdioOut_r;
    assign mdioOe = mdioOe_r;

endmodule

//--- logic/sgan_pkg.sv
/*
 * Shared constants and types for the auto-negotiation management
 * register bank: register addresses, field positions, reset values,
 * management frame codes and the word layouts exchanged with the
 * auto-negotiation state machine.
 * Assumes a single core clock domain and 16-bit management registers.
 */
package sgan_pkg;

    // Register addresses on the management interface
    localparam logic [4:0] REG_ADVERT = 5'h04;
    localparam logic [4:0] REG_PARTNER = 5'h05;
    localparam logic [4:0] REG_EXPANSION = 5'h06;
    localparam logic [4:0] REG_NP_TX = 5'h07;
    localparam logic [4:0] REG_NP_RX = 5'h08;

    // Link word field positions, shared by advertisement and partner words
    localparam int LW_LINK_BIT = 15;
    localparam int LW_ACK_BIT = 14;
    localparam int LW_DUPLEX_BIT = 12;
    localparam int LW_SPEED_LO = 10;
    localparam int LW_ONE_BIT = 0;

    // Expansion register fields
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_NP_ABLE_BIT = 2;

    // Reset and fixed values
    localparam logic [15:0] ADVERT_MAC_VALUE = 16'h0001;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [10:0] NP_CODE_NULL = 11'h001;

    // Management frame codes and bit counts
    localparam logic [1:0] MDIO_OP_READ = 2'h2;
    localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
    localparam logic [4:0] MDIO_HDR_LAST = 5'h0B;
    localparam logic [4:0] MDIO_WR_LAST = 5'h11;
    localparam logic [4:0] MDIO_RD_RELEASE = 5'h12;

    // Speed coding, 11 is reserved
    typedef enum logic [1:0] {
        SPEED_10M = 2'h0,
        SPEED_100M = 2'h1,
        SPEED_1G = 2'h2,
        SPEED_RSVD = 2'h3
    } sgan_speed_t;

    // Base page link word
    typedef struct packed {
        logic link;
        logic ack;
        logic duplex;
        sgan_speed_t speed;
    } sgan_link_word_t;

    localparam sgan_link_word_t LINK_WORD_ZERO = '{link: 1'b0, ack: 1'b0, duplex: 1'b0, speed: SPEED_10M};
    localparam sgan_link_word_t PARTNER_RESET = '{link: 1'b1, ack: 1'b0, duplex: 1'b0, speed: SPEED_10M};

    // Next page word, field order matches the 16-bit register layout
    typedef struct packed {
        logic nextPage;
        logic ack;
        logic msgPage;
        logic comply;
        logic toggle;
        logic [10:0] code;
    } sgan_np_word_t;

    localparam sgan_np_word_t NP_TX_RESET = '{nextPage: 1'b0, ack: 1'b0, msgPage: 1'b0, comply: 1'b0,
                                             toggle: 1'b0, code: NP_CODE_NULL};
    localparam sgan_np_word_t NP_RX_RESET = '{nextPage: 1'b0, ack: 1'b0, msgPage: 1'b0, comply: 1'b0,
                                             toggle: 1'b0, code: 11'h000};

    // One management access, rd and wr are single-cycle pulses
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] data;
    } sgan_mgmt_req_t;

    // Places a link word in its 16-bit register image, bit 0 reads one
    function automatic logic [15:0] sgan_pack_link(input sgan_link_word_t w);
        logic [15:0] v;
        v = ZERO_WORD;
        v[LW_LINK_BIT] = w.link;
        v[LW_ACK_BIT] = w.ack;
        v[LW_DUPLEX_BIT] = w.duplex;
        v[LW_SPEED_LO +: 2] = w.speed;
        v[LW_ONE_BIT] = 1'b1;
        return v;
    endfunction

    // Extracts the writable link fields from a 16-bit image
    function automatic sgan_link_word_t sgan_unpack_link(input logic [15:0] v);
        sgan_link_word_t w;
        w.link = v[LW_LINK_BIT];
        w.ack = v[LW_ACK_BIT];
        w.duplex = v[LW_DUPLEX_BIT];
        w.speed = sgan_speed_t'(v[LW_SPEED_LO +: 2]);
        return w;
    endfunction

endpackage

//--- logic/sgan_reset_ctrl.sv
/*
 * Combines the clock-manager lock input and the soft reset pulse into
 * one synchronous clear for the register bank.
 * Assumes both inputs are synchronous to core_clk.
 */
module sgan_reset_ctrl
    import sgan_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clockManagerLocked,
    input wire logic softReset,
    output logic regClear
);

    logic clear_r;

    // Clear held while lock is lost, one cycle per soft reset pulse
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clear_r <= 1'b1;
        end else begin
            clear_r <= !clockManagerLocked || softReset;
        end
    end

    assign regClear = clear_r;

endmodule

//--- tb/sgan_autoneg_regs_checker.sv
/*
 * Port checker for the auto-negotiation register bank.
 * Assumes one core clock and the asynchronous active-low reset.
 */
module sgan_autoneg_regs_checker
    import sgan_pkg::*;
#(
    parameter bit PHY_MODE = 1'b0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clockManagerLocked,
    input wire logic softReset,
    input wire logic anCfgValid,
    input wire sgan_link_word_t anCfgWord,
    input wire logic [15:0] advertWord,
    input wire sgan_np_word_t npTxWord,
    input wire logic npTxSent,
    input wire logic mdioOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic run;
    logic [4:0] cfgBits;
    // No clear requested in this cycle
    assign run = clockManagerLocked && !softReset;
    assign cfgBits = anCfgWord;
    // A clear lands one cycle after lock loss or soft reset, so the previous cycle must be quiet too
    cfg_load_a: assert property (PHY_MODE && anCfgValid && run && $past(run) |=>
        advertWord == {$past(cfgBits[4:3]), 1'b0, $past(cfgBits[2:0]), 10'h001})
        else $error("advertisement not loaded from config port");
    mac_advert_a: assert property (!PHY_MODE |-> advertWord == 16'h0001)
        else $error("fixed advertisement changed");
    advert_fixed_a: assert property (advertWord[13] == 1'b0 && advertWord[9:0] == 10'h001)
        else $error("reserved advertisement bits wrong");
    // Clear flop registers the request, registers follow one cycle later
    lock_clear_a: assert property (!clockManagerLocked |-> ##2
        (advertWord == 16'h0001 && npTxWord == NP_TX_RESET))
        else $error("lock loss did not clear");
    soft_clear_a: assert property (softReset |-> ##2
        (advertWord == 16'h0001 && npTxWord == NP_TX_RESET))
        else $error("soft reset did not clear");
    toggle_flip_a: assert property (npTxSent && run && $past(run) |=>
        npTxWord.toggle != $past(npTxWord.toggle))
        else $error("toggle did not flip");
    toggle_hold_a: assert property (!npTxSent && run && $past(run) |=> $stable(npTxWord.toggle))
        else $error("toggle moved without a sent page");
    np_ack_zero_a: assert property (npTxWord.ack == 1'b0)
        else $error("next page bit 14 not zero");
    cover property (anCfgValid && run);
    cover property (npTxSent && run);
    cover property ($rose(mdioOe));
endmodule

bind sgan_autoneg_regs sgan_autoneg_regs_checker #(.PHY_MODE(PHY_MODE)) chk_i (.core_clk(core_clk),
    .arst_n(arst_n), .clockManagerLocked(clockManagerLocked), .softReset(softReset), .anCfgValid(anCfgValid),
    .anCfgWord(anCfgWord), .advertWord(advertWord), .npTxWord(npTxWord), .npTxSent(npTxSent), .mdioOe(mdioOe));

//--- tb/sgan_mgmt_master.sv
/*
 * Station management master model: makes mdc and drives frames,
 * releasing the data line after the header of a read.
 * Assumes a pull-up on the shared line and a 100 MHz core_clk.
 */
module sgan_mgmt_master
    import sgan_pkg::*;
(
    input wire logic core_clk,
    input wire logic mdioLine,
    output logic mdc,
    output logic masterOut,
    output logic masterOe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: clock low, line released
    initial begin
        mdc = 1'b0;
        masterOut = 1'b1;
        masterOe = 1'b0;
    end
    // Idle bit, start, op, addresses, turnaround, data, MSB first
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [32:0] f;
        f = {1'b1, 2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 32; i >= 0; i--) begin
            @(posedge core_clk);
            mdc <= 1'b0;
            masterOe <= (op == MDIO_OP_WRITE) || (i >= 18); // Read releases after address
            masterOut <= f[i];
            repeat (4) @(posedge core_clk);
            mdc <= 1'b1;
            repeat (5) @(posedge core_clk);
            rd = {rd[14:0], mdioLine};
        end
        @(posedge core_clk);
        mdc <= 1'b0;
        masterOe <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask
endmodule

//--- tb/test_sgan_autoneg_regs.sv
/*
 * Bench: a PHY mode bank with next pages and a MAC mode bank without,
 * on one shared management line.
 * Assumes the master model and the checker bind.
 */
module test_sgan_autoneg_regs
    import sgan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] PA = 5'h01;
    localparam logic [4:0] MA = 5'h02;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clockManagerLocked = 1'b1;
    logic softReset = 1'b0, anCfgValid = 1'b0, partnerValid = 1'b0;
    logic pageReceived = 1'b0, npTxSent = 1'b0, npRxValid = 1'b0;
    sgan_link_word_t anCfgWord = LINK_WORD_ZERO;
    sgan_link_word_t partnerWord = PARTNER_RESET;
    sgan_np_word_t npRxWord = NP_RX_RESET;
    sgan_np_word_t npTxPhy;
    logic mdc, masterOut, masterOe, mdioLine, oePhy, oeMac, outPhy, outMac;
    logic [15:0] advPhy, advMac;
    int errors = 0;
    int n_compared = 0;
    always #5 core_clk = ~core_clk;
    // Shared line with pull-up
    assign mdioLine = oePhy ? outPhy : (oeMac ? outMac : (masterOe ? masterOut : 1'b1));
    sgan_mgmt_master mm_i (.core_clk(core_clk), .mdioLine(mdioLine), .mdc(mdc), .masterOut(masterOut),
        .masterOe(masterOe));
    sgan_autoneg_regs #(.PHY_MODE(1'b1), .NEXT_PAGE_EN(1'b1)) sgan_autoneg_regs_i (.core_clk(core_clk),
        .arst_n(arst_n), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(outPhy), .mdioOe(oePhy), .phyAddr(PA),
        .clockManagerLocked(clockManagerLocked), .softReset(softReset), .anCfgValid(anCfgValid),
        .anCfgWord(anCfgWord), .advertWord(advPhy), .partnerValid(partnerValid), .partnerWord(partnerWord),
        .pageReceived(pageReceived), .npTxWord(npTxPhy), .npTxSent(npTxSent), .npRxValid(npRxValid),
        .npRxWord(npRxWord));
    sgan_autoneg_regs #(.PHY_MODE(1'b0), .NEXT_PAGE_EN(1'b0)) sgan_autoneg_regs_mac_i (.core_clk(core_clk),
        .arst_n(arst_n), .mdc(mdc), .mdioIn(mdioLine), .mdioOut(outMac), .mdioOe(oeMac), .phyAddr(MA),
        .clockManagerLocked(clockManagerLocked), .softReset(softReset), .anCfgValid(anCfgValid),
        .anCfgWord(anCfgWord), .advertWord(advMac), .partnerValid(partnerValid), .partnerWord(partnerWord),
        .pageReceived(pageReceived), .npTxWord(), .npTxSent(npTxSent), .npRxValid(npRxValid),
        .npRxWord(npRxWord));
    // Word compare
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] d;
        mm_i.xfer(MDIO_OP_READ, pa, ra, 16'h0000, d);
        check(d, exp);
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] x;
        mm_i.xfer(MDIO_OP_WRITE, pa, ra, d, x);
    endtask
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(PA, REG_ADVERT, 16'h0001);
        rd(PA, REG_PARTNER, 16'h8001);
        rd(PA, REG_EXPANSION, 16'h0004);
        rd(PA, REG_NP_TX, 16'h0001);
        rd(PA, REG_NP_RX, 16'h0000);
        rd(PA, 5'h09, 16'h0000);
        $display("defaults done");
        for (int s = 0; s < 4; s++) begin
            wr(PA, REG_ADVERT, {4'h0, 2'(s), 10'h000});
            rd(PA, REG_ADVERT, {4'h0, 2'(s), 10'h001});
        end
        wr(PA, REG_ADVERT, 16'hFFFF);
        rd(PA, REG_ADVERT, 16'hDC01);
        check(advPhy, 16'hDC01);
        wr(MA, REG_ADVERT, 16'hFFFF);
        rd(MA, REG_ADVERT, 16'h0001);
        rd(MA, REG_NP_TX, 16'h0000);
        $display("advertisement done");
        anCfgWord <= '{link: 1'b0, ack: 1'b1, duplex: 1'b0, speed: SPEED_1G};
        anCfgValid <= 1'b1;
        @(posedge core_clk);
        anCfgValid <= 1'b0;
        @(posedge core_clk);
        check(advPhy, 16'h4801);
        check(advMac, 16'h0001);
        rd(PA, REG_ADVERT, 16'h4801);
        partnerWord <= '{link: 1'b1, ack: 1'b1, duplex: 1'b1, speed: SPEED_100M};
        partnerValid <= 1'b1;
        @(posedge core_clk);
        partnerValid <= 1'b0;
        wr(PA, REG_PARTNER, 16'h0000);
        rd(PA, REG_PARTNER, 16'hD401);
        $display("config and partner done");
        pageReceived <= 1'b1;
        @(posedge core_clk);
        pageReceived <= 1'b0;
        rd(PA, REG_EXPANSION, 16'h0006);
        rd(PA, REG_EXPANSION, 16'h0004);
        wr(PA, REG_NP_TX, 16'hFFFF);
        rd(PA, REG_NP_TX, 16'hB7FF);
        check(npTxPhy, 16'hB7FF);
        for (int k = 0; k < 2; k++) begin
            npTxSent <= 1'b1;
            @(posedge core_clk);
            npTxSent <= 1'b0;
            rd(PA, REG_NP_TX, (k == 0) ? 16'hBFFF : 16'hB7FF);
            check(npTxPhy, (k == 0) ? 16'hBFFF : 16'hB7FF);
        end
        npRxWord <= sgan_np_word_t'(16'h9ABC);
        npRxValid <= 1'b1;
        @(posedge core_clk);
        npRxValid <= 1'b0;
        wr(PA, REG_NP_RX, 16'h0000);
        rd(PA, REG_NP_RX, 16'h9ABC);
        $display("pages done");
        softReset <= 1'b1;
        @(posedge core_clk);
        softReset <= 1'b0;
        rd(PA, REG_ADVERT, 16'h0001);
        rd(PA, REG_PARTNER, 16'h8001);
        rd(PA, REG_NP_RX, 16'h0000);
        wr(PA, REG_NP_TX, 16'hFFFF);
        clockManagerLocked <= 1'b0;
        repeat (3) @(posedge core_clk);
        clockManagerLocked <= 1'b1;
        rd(PA, REG_NP_TX, 16'h0001);
        check(npTxPhy, 16'h0001);
        wr(PA, REG_ADVERT, 16'hFFFF);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(PA, REG_ADVERT, 16'h0001);
        $display("clears done");
        end_of_test();
    end
endmodule
